// >>> iap_flash_map.svh
// offsets, field positions, reset values and timing counts of the flash
// programming sequencer; included by the package and both ends
// How it works
// - 64-word buffer maps one page
// - low then high data loads word
// - buffer address saturates at last word
// - op 001, clear, trigger: erase page
// - op 000, trigger: program buffer to flash
// - time select picks erase/write duration
// - cpu stalled while erase or write runs
// - erase and write need unlock status
// - erase clears only the tagged words of a page
// - write programs whole buffer as page
// - failed verify: clear, reload, rewrite
// - op 011 plus enable plus trigger reads
// - read trigger drops after three instructions
// - reads work without unlock
// - clearing unlock status blocks erase, write
// - software runs fastest clock while programming
// - low write stores; high write loads, increments
// - hardware sets unlock status on success
// - high data writes tag erase addresses
`ifndef IAP_FLASH_MAP_SVH
`define IAP_FLASH_MAP_SVH
`define IAP_PAGE_WORDS 64
`define IAP_IDX_W 6
`define IAP_ADDR_W 15
`define IAP_OP_WRITE 3'h0
`define IAP_OP_ERASE 3'h1
`define IAP_OP_READ 3'h3
`define IAP_C0_RDEN 3
`define IAP_C0_UNLOCK 4
`define IAP_C0_RDTRIG 5
`define IAP_C0_PTRIG 6
`define IAP_C2_TSEL 0
`define IAP_C2_BUFCLR 1
`define IAP_REG_RESET 8'h00
`define IAP_CLK_NS 10
`define IAP_EW_SHORT_US 2000
`define IAP_EW_LONG_US 4000
`define IAP_RD_INSTR 3
`define IAP_INSTR_CLKS 4
`define IAP_RD_CYCLES (`IAP_RD_INSTR * `IAP_INSTR_CLKS)
`endif

// >>> iap_flash_pkg.sv
// types shared by the sequencer ends and the link interface
// assumes iap_flash_map.svh is on the include path
`include "iap_flash_map.svh"
package iap_flash_pkg;
    typedef enum logic [2:0] {SEL_CTRL0, SEL_CTRL2, SEL_ADDR_LO, SEL_ADDR_HI,
        SEL_DATA_LO, SEL_DATA_HI} reg_sel_t;
    typedef enum logic [1:0] {DEV_IDLE, DEV_STREAM, DEV_TIMED, DEV_READ} dev_state_t;
    typedef enum logic [2:0] {CMD_SET_ADDR, CMD_LOAD_WORD, CMD_CLEAR, CMD_ERASE,
        CMD_WRITE, CMD_READ, CMD_LOCK} host_cmd_t;
    typedef enum logic [1:0] {H_IDLE, H_ISSUE, H_WAIT} host_state_t;
    typedef struct packed {
        reg_sel_t sel;
        logic [7:0] wdata;
        logic last;
    } host_item_t;
    typedef struct packed {
        dev_state_t st;
        logic [2:0] op;
        logic rden;
        logic unlock;
        logic rtrig;
        logic ptrig;
        logic tsel;
        logic [`IAP_ADDR_W-1:0] addr;
        logic [7:0] dlo;
        logic [7:0] dhi;
        logic [`IAP_PAGE_WORDS-1:0] tag;
        logic [`IAP_PAGE_WORDS-1:0][15:0] wbuf;
        logic [`IAP_IDX_W-1:0] idx;
        logic fl_wr;
        logic fl_er;
        logic fl_rd;
        logic cap;
        logic [`IAP_ADDR_W-1:0] fl_addr;
        logic [15:0] fl_wdata;
    } dev_reg_t;
    typedef struct packed {
        host_state_t st;
        host_cmd_t cmd;
        logic [`IAP_ADDR_W-1:0] addr;
        logic [15:0] data;
        logic tsel;
        logic [1:0] step;
        logic reg_wr;
        reg_sel_t sel;
        logic [7:0] wdata;
        logic rsp_v;
        logic [15:0] rsp_d;
    } host_reg_t;
endpackage

// >>> iap_link_if.sv
// register link between the cpu-side master and the flash sequencer
// both ends run on one clock; write strobes are one-cycle pulses
`include "iap_flash_map.svh"
interface iap_link_if;
    logic reg_wr;
    iap_flash_pkg::reg_sel_t reg_sel;
    logic [7:0] reg_wdata;
    logic [7:0] ctrl0_rd;
    logic [7:0] ctrl2_rd;
    logic [`IAP_ADDR_W-1:0] addr_rd;
    logic [15:0] data_rd;
    logic stall;
    modport dev (input reg_wr, reg_sel, reg_wdata,
        output ctrl0_rd, ctrl2_rd, addr_rd, data_rd, stall);
    modport host (output reg_wr, reg_sel, reg_wdata,
        input ctrl0_rd, ctrl2_rd, addr_rd, data_rd, stall);
endinterface

// >>> iap_cycle_timer.sv
// down-counter timing erase, write and read durations
// value_i is sampled on load_i; done_o pulses after value_i cycles
module iap_cycle_timer #(
    parameter int unsigned W = 20
) (
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic load_i,
    input wire logic [W-1:0] value_i,
    output logic done_o
);
    typedef struct packed {
        logic [W-1:0] cnt;
    } tmr_reg_t;
    tmr_reg_t q;
    tmr_reg_t d;

    // load wins; otherwise count down to zero and rest there
    always_comb begin
        d = q;
        if (load_i) begin
            d.cnt = value_i;
        end else if (q.cnt != '0) begin
            d.cnt = q.cnt - W'(1);
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign done_o = (q.cnt == W'(1));
endmodule

// >>> iap_flash_dev.sv
// flash programming sequencer, device end: control, address and data
// registers, 64-word page buffer, erase/write/read sequencing
// assumes a flash macro on clk_sys_i whose read data follows rd by one cycle
// assumes unlock_done_i comes from unlock logic on the same clock
// limitation: writes sent while stalled are lost, except a lock
`include "iap_flash_map.svh"
module iap_flash_dev #(
    parameter int unsigned EW_SHORT_CYCLES = (`IAP_EW_SHORT_US * 1000) / `IAP_CLK_NS,
    parameter int unsigned EW_LONG_CYCLES = (`IAP_EW_LONG_US * 1000) / `IAP_CLK_NS,
    parameter int unsigned TIMER_W = 20
) (
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    iap_link_if.dev link,
    input wire logic unlock_done_i,
    output logic flash_erase_o,
    output logic flash_wr_o,
    output logic flash_rd_o,
    output logic [`IAP_ADDR_W-1:0] flash_addr_o,
    output logic [15:0] flash_wdata_o,
    output logic [`IAP_PAGE_WORDS-1:0] flash_tag_o,
    input wire logic [15:0] flash_rdata_i
);
    // constants sized to the fields they meet
    localparam logic [`IAP_IDX_W-1:0] LAST_IDX = `IAP_IDX_W'(`IAP_PAGE_WORDS - 1);
    localparam logic [TIMER_W-1:0] RD_CYC = TIMER_W'(`IAP_RD_CYCLES);
    localparam logic [TIMER_W-1:0] EW_SHORT = TIMER_W'(EW_SHORT_CYCLES);
    localparam logic [TIMER_W-1:0] EW_LONG = TIMER_W'(EW_LONG_CYCLES);

    // the timer must hold the longest count and no count may be zero
    if (EW_SHORT_CYCLES < 1 || EW_LONG_CYCLES < 1 || `IAP_RD_CYCLES < 1 ||
        EW_SHORT_CYCLES >= (64'd1 << TIMER_W) || EW_LONG_CYCLES >= (64'd1 << TIMER_W)) begin
        $error("iap_flash_dev: timer width too small or zero count");
    end

    // the index must span the page exactly, or saturation lands wrong
    if (`IAP_PAGE_WORDS != (1 << `IAP_IDX_W)) begin
        $error("iap_flash_dev: page size and index width disagree");
    end

    // all sequencer state in one struct register
    iap_flash_pkg::dev_reg_t q;
    iap_flash_pkg::dev_reg_t d;
    logic tmr_load;
    logic [TIMER_W-1:0] tmr_val;
    logic tmr_done;
    logic [2:0] w_op;
    logic [`IAP_IDX_W-1:0] widx;

    // one shared timer: erase/write windows and the read window never overlap
    iap_cycle_timer #(
        .W(TIMER_W)
    ) u_timer (
        .clk_sys_i(clk_sys_i),
        .rstn_i(rstn_i),
        .load_i(tmr_load),
        .value_i(tmr_val),
        .done_o(tmr_done)
    );

    // op field and buffer index, shared by the case arms
    assign w_op = link.reg_wdata[2:0];
    assign widx = q.addr[`IAP_IDX_W-1:0];

    // next-state logic of the whole sequencer
    always_comb begin
        d = q;
        d.fl_wr = 1'b0;
        d.fl_er = 1'b0;
        d.fl_rd = 1'b0;
        d.cap = q.fl_rd;
        tmr_load = 1'b0;
        tmr_val = q.tsel ? EW_LONG : EW_SHORT;
        // read data arrives one cycle after the read strobe
        if (q.cap) begin
            d.dlo = flash_rdata_i[7:0];
            d.dhi = flash_rdata_i[15:8];
        end
        unique case (q.st)
            iap_flash_pkg::DEV_IDLE: begin
                // register writes are taken only while idle, except a lock; the cpu is stalled otherwise
                if (link.reg_wr) begin
                    unique case (link.reg_sel)
                        iap_flash_pkg::SEL_CTRL0: begin
                            d.op = w_op;
                            d.rden = link.reg_wdata[`IAP_C0_RDEN];
                            // a trigger refused by the lock simply never sets
                            if (link.reg_wdata[`IAP_C0_PTRIG] && q.unlock) begin
                                if (w_op == `IAP_OP_ERASE) begin
                                    d.ptrig = 1'b1;
                                    d.fl_er = 1'b1;
                                    d.fl_addr = {q.addr[`IAP_ADDR_W-1:`IAP_IDX_W],
                                        `IAP_IDX_W'(0)};
                                    tmr_load = 1'b1;
                                    d.st = iap_flash_pkg::DEV_TIMED;
                                end else if (w_op == `IAP_OP_WRITE) begin
                                    d.ptrig = 1'b1;
                                    d.idx = '0;
                                    d.st = iap_flash_pkg::DEV_STREAM;
                                end
                            end else if (link.reg_wdata[`IAP_C0_RDTRIG] &&
                                w_op == `IAP_OP_READ && link.reg_wdata[`IAP_C0_RDEN]) begin
                                // no unlock check here on purpose
                                d.rtrig = 1'b1;
                                d.fl_rd = 1'b1;
                                d.fl_addr = q.addr;
                                tmr_load = 1'b1;
                                tmr_val = RD_CYC;
                                d.st = iap_flash_pkg::DEV_READ;
                            end
                        end
                        iap_flash_pkg::SEL_CTRL2: begin
                            d.tsel = link.reg_wdata[`IAP_C2_TSEL];
                            // clear strobe is not stored: it reads back as zero
                            if (link.reg_wdata[`IAP_C2_BUFCLR]) begin
                                d.wbuf = '0;
                                // tags survive: the erase that follows needs them
                                d.addr[`IAP_IDX_W-1:0] = '0;
                            end
                        end
                        iap_flash_pkg::SEL_ADDR_LO: begin
                            d.addr[7:0] = link.reg_wdata;
                        end
                        iap_flash_pkg::SEL_ADDR_HI: begin
                            // only seven address bits sit in the high byte
                            d.addr[`IAP_ADDR_W-1:8] = link.reg_wdata[`IAP_ADDR_W-9:0];
                        end
                        iap_flash_pkg::SEL_DATA_LO: begin
                            // held only; the buffer is untouched
                            d.dlo = link.reg_wdata;
                        end
                        iap_flash_pkg::SEL_DATA_HI: begin
                            // the high byte commits the word and tags it
                            d.dhi = link.reg_wdata;
                            d.wbuf[widx] = {link.reg_wdata, q.dlo};
                            d.tag[widx] = 1'b1;
                            // stays on the last word of the page
                            if (widx != LAST_IDX) begin
                                d.addr = q.addr + `IAP_ADDR_W'(1);
                            end
                        end
                    endcase
                end
            end
            iap_flash_pkg::DEV_STREAM: begin
                // the whole buffer goes out as one page, one word per cycle
                d.fl_wr = 1'b1;
                d.fl_addr = {q.addr[`IAP_ADDR_W-1:`IAP_IDX_W], q.idx};
                d.fl_wdata = q.wbuf[q.idx];
                d.idx = q.idx + `IAP_IDX_W'(1);
                if (q.idx == LAST_IDX) begin
                    // window starts in the same cycle the last word goes out
                    tmr_load = 1'b1;
                    d.st = iap_flash_pkg::DEV_TIMED;
                end
            end
            iap_flash_pkg::DEV_TIMED: begin
                // trigger and stall stand until the window runs out
                if (tmr_done) begin
                    d.ptrig = 1'b0;
                    d.st = iap_flash_pkg::DEV_IDLE;
                    // tags are spent once their page is erased
                    if (q.op == `IAP_OP_ERASE) begin
                        d.tag = '0;
                    end
                end
            end
            iap_flash_pkg::DEV_READ: begin
                // fixed read window; the time select does not apply
                if (tmr_done) begin
                    d.rtrig = 1'b0;
                    d.st = iap_flash_pkg::DEV_IDLE;
                end
            end
        endcase
        // writing zero to the unlock bit locks; hardware success wins the same cycle
        // a lock is taken even while the cpu is stalled
        if (link.reg_wr && link.reg_sel == iap_flash_pkg::SEL_CTRL0 &&
            !link.reg_wdata[`IAP_C0_UNLOCK]) begin
            d.unlock = 1'b0;
        end
        if (unlock_done_i) begin
            d.unlock = 1'b1;
        end
    end

    // reset clears every field, so all flags start low
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // readback and flash strobes all come from state flip-flops
    assign link.ctrl0_rd = {1'b0, q.ptrig, q.rtrig, q.unlock, q.rden, q.op};
    assign link.ctrl2_rd = {7'h00, q.tsel};
    assign link.addr_rd = q.addr;
    assign link.data_rd = {q.dhi, q.dlo};
    assign link.stall = (q.st != iap_flash_pkg::DEV_IDLE);

    // flash macro strobes, address and data
    assign flash_erase_o = q.fl_er;
    assign flash_wr_o = q.fl_wr;
    assign flash_rd_o = q.fl_rd;
    assign flash_addr_o = q.fl_addr;
    assign flash_wdata_o = q.fl_wdata;
    assign flash_tag_o = q.tag;
endmodule

// >>> iap_flash_host.sv
// flash programming sequencer, cpu end: turns one command into the
// register write script and waits out the trigger
// assumes the device end on the same clock through iap_link_if
`include "iap_flash_map.svh"
module iap_flash_host (
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    iap_link_if.host link,
    input wire logic cmd_valid_i,
    input wire iap_flash_pkg::host_cmd_t cmd_i,
    input wire logic [`IAP_ADDR_W-1:0] cmd_addr_i,
    input wire logic [15:0] cmd_data_i,
    input wire logic cmd_long_i,
    output logic cmd_ready_o,
    output logic rsp_valid_o,
    output logic [15:0] rsp_data_o
);
    iap_flash_pkg::host_reg_t q;
    iap_flash_pkg::host_reg_t d;
    iap_flash_pkg::host_item_t it;

    // control byte with the unlock bit kept at one so it is not dropped
    function automatic logic [7:0] c0(input logic [2:0] op, input logic [7:0] bits);
        c0 = {5'h00, op} | bits | (8'h01 << `IAP_C0_UNLOCK);
    endfunction

    // script of register writes per command, one item per step
    always_comb begin
        it = '{sel: iap_flash_pkg::SEL_CTRL0, wdata: 8'h00, last: 1'b1};
        unique case (q.cmd)
            iap_flash_pkg::CMD_SET_ADDR: begin
                it.sel = q.step[0] ? iap_flash_pkg::SEL_ADDR_HI : iap_flash_pkg::SEL_ADDR_LO;
                it.wdata = q.step[0] ? {1'b0, q.addr[`IAP_ADDR_W-1:8]} : q.addr[7:0];
                it.last = q.step[0];
            end
            iap_flash_pkg::CMD_LOAD_WORD: begin
                // low byte first, the high byte commits the word
                it.sel = q.step[0] ? iap_flash_pkg::SEL_DATA_HI : iap_flash_pkg::SEL_DATA_LO;
                it.wdata = q.step[0] ? q.data[15:8] : q.data[7:0];
                it.last = q.step[0];
            end
            iap_flash_pkg::CMD_CLEAR: begin
                it.sel = iap_flash_pkg::SEL_CTRL2;
                it.wdata = {6'h00, 1'b1, q.tsel};
            end
            iap_flash_pkg::CMD_ERASE, iap_flash_pkg::CMD_WRITE: begin
                it.sel = (q.step == 2'd1) ? iap_flash_pkg::SEL_CTRL2 : iap_flash_pkg::SEL_CTRL0;
                it.last = (q.step == 2'd2);
                if (q.step == 2'd1) begin
                    it.wdata = {6'h00, (q.cmd == iap_flash_pkg::CMD_ERASE), q.tsel};
                end else begin
                    it.wdata = c0((q.cmd == iap_flash_pkg::CMD_ERASE) ? `IAP_OP_ERASE :
                        `IAP_OP_WRITE, q.step[1] ? (8'h01 << `IAP_C0_PTRIG) : 8'h00);
                end
            end
            iap_flash_pkg::CMD_READ: begin
                it.wdata = c0(`IAP_OP_READ, (8'h01 << `IAP_C0_RDEN) |
                    (q.step[0] ? (8'h01 << `IAP_C0_RDTRIG) : 8'h00));
                it.last = q.step[0];
            end
            iap_flash_pkg::CMD_LOCK: begin
                it.wdata = {5'h00, `IAP_OP_WRITE};
            end
        endcase
    end

    // command sequencing
    always_comb begin
        d = q;
        d.reg_wr = 1'b0;
        d.rsp_v = 1'b0;
        unique case (q.st)
            iap_flash_pkg::H_IDLE: begin
                if (cmd_valid_i) begin
                    d.cmd = cmd_i;
                    d.addr = cmd_addr_i;
                    d.data = cmd_data_i;
                    d.tsel = cmd_long_i;
                    d.step = 2'd0;
                    d.st = iap_flash_pkg::H_ISSUE;
                end
            end
            iap_flash_pkg::H_ISSUE: begin
                d.reg_wr = 1'b1;
                d.sel = it.sel;
                d.wdata = it.wdata;
                d.step = q.step + 2'd1;
                if (it.last) begin
                    d.st = iap_flash_pkg::H_WAIT;
                end
            end
            iap_flash_pkg::H_WAIT: begin
                // skip the cycle the last write is still on the link
                if (!q.reg_wr && !link.stall &&
                    !link.ctrl0_rd[`IAP_C0_PTRIG] && !link.ctrl0_rd[`IAP_C0_RDTRIG]) begin
                    d.rsp_v = 1'b1;
                    d.rsp_d = link.data_rd;
                    d.st = iap_flash_pkg::H_IDLE;
                end
            end
            default: begin
                d.st = iap_flash_pkg::H_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign cmd_ready_o = (q.st == iap_flash_pkg::H_IDLE);
    assign link.reg_wr = q.reg_wr;
    assign link.reg_sel = q.sel;
    assign link.reg_wdata = q.wdata;
    assign rsp_valid_o = q.rsp_v;
    assign rsp_data_o = q.rsp_d;
endmodule

// >>> iap_flash_checker.sv
// concurrent checks on the register link between host end and device end
// assumes one clock and an active-low reset shared by both ends
`include "iap_flash_map.svh"
module iap_flash_checker (
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic reg_wr,
    input wire iap_flash_pkg::reg_sel_t reg_sel,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] ctrl0_rd,
    input wire logic [7:0] ctrl2_rd,
    input wire logic [`IAP_ADDR_W-1:0] addr_rd,
    input wire logic [15:0] data_rd,
    input wire logic stall
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);
    // a write counts here only while the device is not stalling the cpu; the device also takes a lock while stalled
    logic take;
    assign take = reg_wr && !stall;
    sequence read_req;
        take && reg_sel == iap_flash_pkg::SEL_CTRL0 && reg_wdata[2:0] == 3'h3
            && reg_wdata[3] && reg_wdata[5];
    endsequence
    // trigger and stall stand together, then the trigger drops near twelve clocks
    sequence read_busy;
        ##1 (stall && ctrl0_rd[5])[*8] ##[3:5] !ctrl0_rd[5];
    endsequence
    sequence ew_req;
        take && reg_sel == iap_flash_pkg::SEL_CTRL0 && reg_wdata[6];
    endsequence
    a_read_busy_time: assert property (read_req |-> read_busy)
        else $error("read trigger timing wrong");
    a_locked_refuse: assert property (ew_req and (!ctrl0_rd[4]) |=> !ctrl0_rd[6] && !stall)
        else $error("erase or write started while locked");
    a_trig_accept_stall: assert property (ew_req and (ctrl0_rd[4] && reg_wdata[4]
        && reg_wdata[2:1] == 2'h0) |=> ctrl0_rd[6] && stall)
        else $error("accepted trigger did not stall");
    a_load_advance: assert property (take && reg_sel == iap_flash_pkg::SEL_DATA_HI
        && addr_rd[5:0] != 6'h3f |=> addr_rd == $past(addr_rd) + 15'h0001)
        else $error("high data load did not advance address");
    a_load_saturate: assert property (take && reg_sel == iap_flash_pkg::SEL_DATA_HI
        && addr_rd[5:0] == 6'h3f |=> $stable(addr_rd))
        else $error("address moved past last word");
    a_low_store_only: assert property (take && reg_sel == iap_flash_pkg::SEL_DATA_LO
        |=> $stable(addr_rd) && data_rd[7:0] == $past(reg_wdata))
        else $error("low data write misbehaved");
    a_clear_index: assert property (take && reg_sel == iap_flash_pkg::SEL_CTRL2
        && reg_wdata[1] |=> addr_rd[5:0] == 6'h00 && $stable(addr_rd[14:6]))
        else $error("buffer clear left index");
    a_time_select: assert property (take && reg_sel == iap_flash_pkg::SEL_CTRL2
        |=> ctrl2_rd[0] == $past(reg_wdata[0]) && !ctrl2_rd[1])
        else $error("time select not stored");
    a_lock_clears: assert property (take && reg_sel == iap_flash_pkg::SEL_CTRL0
        && !reg_wdata[4] |=> !ctrl0_rd[4])
        else $error("unlock status not cleared");
endmodule

// >>> iap_flash_page_program_read_test.sv
// testbench: host end and device end joined by the link, flash macro mocked
// assumes the design files and iap_flash_map.svh are compiled first
`include "iap_flash_map.svh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[ERR] %s exp %h got %h", nm, e, g); end end
module iap_flash_page_program_read_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int SHORT = 20;
    localparam int LONG = 40;
    logic clk_sys_i = 0, rstn_i = 0, unlock_done = 0, cmd_valid = 0, cmd_long = 0;
    iap_flash_pkg::host_cmd_t cmd = iap_flash_pkg::CMD_SET_ADDR;
    logic [14:0] cmd_addr = 15'h0, f_addr, er_addr;
    logic [15:0] cmd_data = 16'h0, f_rdata = 16'h0, f_wdata, rsp_data, rsp;
    logic f_er, f_wr, f_rd, ready, rsp_v;
    logic [63:0] f_tag, er_tag;
    logic [15:0] wr_seen [64];
    int n_mismatch = 0, cmp_count = 0, n_wr = 0, n_er = 0, n_busy = 0;
    iap_link_if link ();
    iap_flash_dev #(.EW_SHORT_CYCLES(SHORT), .EW_LONG_CYCLES(LONG)) iap_flash_dev_inst (
        .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .link(link), .unlock_done_i(unlock_done),
        .flash_erase_o(f_er), .flash_wr_o(f_wr), .flash_rd_o(f_rd), .flash_addr_o(f_addr),
        .flash_wdata_o(f_wdata), .flash_tag_o(f_tag), .flash_rdata_i(f_rdata));
    iap_flash_host iap_flash_host_inst (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
        .link(link), .cmd_valid_i(cmd_valid), .cmd_i(cmd), .cmd_addr_i(cmd_addr),
        .cmd_data_i(cmd_data), .cmd_long_i(cmd_long), .cmd_ready_o(ready),
        .rsp_valid_o(rsp_v), .rsp_data_o(rsp_data));
    iap_flash_checker iap_flash_checker_inst (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
        .reg_wr(link.reg_wr), .reg_sel(link.reg_sel), .reg_wdata(link.reg_wdata),
        .ctrl0_rd(link.ctrl0_rd), .ctrl2_rd(link.ctrl2_rd), .addr_rd(link.addr_rd),
        .data_rd(link.data_rd), .stall(link.stall));
    initial forever #5 clk_sys_i = ~clk_sys_i;
    // mock flash: contents derive from the address, so any read has a known answer
    always @(negedge clk_sys_i) f_rdata <= {1'b0, f_addr} ^ 16'ha5a5;
    // monitor of flash strobes and trigger time, mid-cycle where they are settled
    always @(negedge clk_sys_i) begin
        if (f_wr && n_wr < 64) wr_seen[n_wr] = f_wdata;
        if (f_wr) n_wr++;
        if (f_er) n_er++;
        if (f_er) er_addr = f_addr;
        if (f_er) er_tag = f_tag;
        if (link.ctrl0_rd[6]) n_busy++;
    end
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // one host command; inputs held from a falling edge until the taking edge
    task automatic run(input iap_flash_pkg::host_cmd_t c, input logic [14:0] a,
            input logic [15:0] d, input logic lng);
        int i;
        cmd = c;
        cmd_addr = a;
        cmd_data = d;
        cmd_long = lng;
        cmd_valid = 1'b1;
        for (i = 0; i < 50 && ready !== 1'b1; i++) @(negedge clk_sys_i);
        if (ready !== 1'b1) begin
            n_mismatch++;
            stop_test();
        end
        @(negedge clk_sys_i);
        cmd_valid = 1'b0;
        for (i = 0; i < 2000 && rsp_v !== 1'b1; i++) @(negedge clk_sys_i);
        rsp = rsp_data;
        if (rsp_v !== 1'b1) begin
            n_mismatch++;
            $display("[ERR] rsp_valid_o exp 1 got %b", rsp_v);
            stop_test();
        end else @(negedge clk_sys_i);
    endtask
    task automatic t_locked();
        n_er = 0;
        n_busy = 0;
        run(iap_flash_pkg::CMD_ERASE, 15'h0040, 16'h0, 1'b0);
        `CHK("locked erase", 0, n_er)
        `CHK("locked busy", 0, n_busy)
    endtask
    task automatic t_read();
        // no unlock has happened yet, the read must still work
        run(iap_flash_pkg::CMD_SET_ADDR, 15'h1234, 16'h0, 1'b0);
        run(iap_flash_pkg::CMD_READ, 15'h1234, 16'h0, 1'b0);
        `CHK("read data", 16'h1234 ^ 16'ha5a5, rsp)
        `CHK("read unlock", 1'b0, link.ctrl0_rd[4])
    endtask
    task automatic t_unlock();
        unlock_done = 1'b1;
        @(negedge clk_sys_i);
        unlock_done = 1'b0;
        @(negedge clk_sys_i);
        `CHK("unlock status", 1'b1, link.ctrl0_rd[4])
    endtask
    task automatic t_erase();
        int i;
        run(iap_flash_pkg::CMD_CLEAR, 15'h0, 16'h0, 1'b0);
        run(iap_flash_pkg::CMD_SET_ADDR, 15'h0a80, 16'h0, 1'b0);
        for (i = 0; i < 3; i++) run(iap_flash_pkg::CMD_LOAD_WORD, 15'h0, 16'hffff, 1'b0);
        `CHK("tags", 64'h7, f_tag)
        n_er = 0;
        n_busy = 0;
        run(iap_flash_pkg::CMD_ERASE, 15'h0a80, 16'h0, 1'b0);
        `CHK("erase count", 1, n_er)
        `CHK("erase tags", 64'h7, er_tag)
        `CHK("erase page", 9'h02a, er_addr[14:6])
        `CHK("short time", 1'b1, n_busy >= SHORT && n_busy <= SHORT + 4)
        n_busy = 0;
        run(iap_flash_pkg::CMD_ERASE, 15'h0a80, 16'h0, 1'b1);
        `CHK("long time", 1'b1, n_busy >= LONG && n_busy <= LONG + 4)
    endtask
    task automatic t_page();
        int i;
        run(iap_flash_pkg::CMD_CLEAR, 15'h0, 16'h0, 1'b0);
        `CHK("spent tags", 64'h0, f_tag)
        run(iap_flash_pkg::CMD_SET_ADDR, 15'h0a80, 16'h0, 1'b0);
        for (i = 0; i < 64; i++) run(iap_flash_pkg::CMD_LOAD_WORD, 15'h0, 16'h1000 + i, 1'b0);
        `CHK("last index", 15'h0abf, link.addr_rd)
        run(iap_flash_pkg::CMD_LOAD_WORD, 15'h0, 16'hbeef, 1'b0);
        `CHK("held index", 15'h0abf, link.addr_rd)
        n_wr = 0;
        run(iap_flash_pkg::CMD_WRITE, 15'h0a80, 16'h0, 1'b0);
        `CHK("word count", 64, n_wr)
        for (i = 0; i < 64; i++) `CHK("word", (i == 63) ? 16'hbeef : 16'h1000 + i, wr_seen[i])
    endtask
    task automatic t_retry();
        // failed verify: clear, reload one word, rewrite the same page unerased
        run(iap_flash_pkg::CMD_CLEAR, 15'h0, 16'h0, 1'b0);
        run(iap_flash_pkg::CMD_LOAD_WORD, 15'h0, 16'h5a5a, 1'b0);
        n_wr = 0;
        n_er = 0;
        run(iap_flash_pkg::CMD_WRITE, 15'h0a80, 16'h0, 1'b0);
        `CHK("retry word", 16'h5a5a, wr_seen[0])
        `CHK("cleared word", 16'h0, wr_seen[1])
        `CHK("retry erase", 0, n_er)
    endtask
    task automatic t_lock();
        run(iap_flash_pkg::CMD_LOCK, 15'h0, 16'h0, 1'b0);
        `CHK("locked again", 1'b0, link.ctrl0_rd[4])
        n_wr = 0;
        run(iap_flash_pkg::CMD_WRITE, 15'h0a80, 16'h0, 1'b0);
        `CHK("locked write", 0, n_wr)
    endtask
    initial begin
        repeat (20) @(negedge clk_sys_i);
        rstn_i = 1'b1;
        @(negedge clk_sys_i);
        `CHK("reset ctrl0", 8'h00, link.ctrl0_rd)
        `CHK("reset addr", 15'h0, link.addr_rd)
        t_locked();
        t_read();
        t_unlock();
        t_erase();
        t_page();
        t_retry();
        t_lock();
        stop_test();
    end
endmodule
